// [include/svm_map.vh]
`ifndef SVM_MAP_VH
`define SVM_MAP_VH
// Register byte offsets
`define SVM_OFF_STATUS_CONTROL 4'h0
`define SVM_OFF_CONFIG         4'h1
`define SVM_OFF_EVENT_STATUS   4'h2
`define SVM_OFF_EVENT_CLEAR    4'h3
`define SVM_OFF_EVENT_ENABLE   4'h4
// Status/control field positions
`define SVM_BIT_FLAG           7
`define SVM_BIT_TOL            0
// Config field positions
`define SVM_BIT_PWR            0
`define SVM_BIT_RST            1
// Event bit positions
`define SVM_EV_FLAG_SET        0
`define SVM_EV_MON_RESET       1
`define SVM_EV_WIDTH           2
// Reset values
`define SVM_RST_TOL            1'b0
`define SVM_RST_PWR            1'b1
`define SVM_RST_RST            1'b1
// Timing counts
`define SVM_RESET_FILTER_CYC   9
`define SVM_FLAG_MIN_CYC       32
`define SVM_FLAG_MAX_CYC       40
`define SVM_FLAG_CYC           36
`define SVM_CNT_W              6
`endif

// [rtl/svm_filter_cnt.v]
`default_nettype none
// Saturating run-length counter with threshold compare
module svm_filter_cnt #(
   parameter [5:0] THRESH = 6'h01
) (
   // Clock and reset
   input  wire       clk_in,
   input  wire       rst_b_in,
   // Control
   input  wire       run_in,
   input  wire       clr_in,
   // Result
   output wire       hit_out
);
   reg [5:0] cnt_q;
   // Count while run, saturate at threshold so no wrap
   always @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cnt_q <= 6'h00;
      end else if (clr_in || !run_in) begin
         cnt_q <= 6'h00;
      end else if (cnt_q != THRESH) begin
         cnt_q <= cnt_q + 6'h01;
      end
   end
   assign hit_out = (cnt_q == THRESH);
endmodule // svm_filter_cnt
`default_nettype wire

// [rtl/svm_monitor.v]
// Functional notes
// (R1) Polling mode: power on, reset off; software reads the filtered flag.
// (R2) Power and reset enabled: reset after nine consecutive low samples.
// (R3) Reset released after one cycle above recovery point.
// (R4) Tolerance select resets to zero (10 percent); one selects 5 percent.
// (R5) Tolerance one routes first threshold pair, zero the second pair.
// (R6) Low-supply flag is read-only, ignores writes, cleared by reset.
// (R7) Flag zero under 32 low crystal cycles, one after 40.
// (R8) Flag zero above recovery point, holds between trip and recovery.
// (R9) Tolerance change triggers reset if supply below the new trip.
// (R10) No processor interrupt request; only flag and reset request.
// (R11) Keeps running in wait standby; reset ends wait.
// (R12) Keeps running in stop standby; reset ends stop.
// (R13) Monitor enabled straight out of reset.
// (R14) Monitor reset also drives the external reset pin low.
//
// The register offsets and the strobed register port were decided locally.
`include "svm_map.vh"
`default_nettype none
module svm_monitor (
   // Clocks and reset
   input  wire       core_clk_in,
   input  wire       rst_b_in,
   input  wire       xtal_clk_in,
   // Analog comparator
   input  wire       below_trip_in,
   input  wire       above_recovery_in,
   output wire       threshold_pair_sel_out,
   output wire       comparator_power_out,
   // Register port
   input  wire [3:0] reg_addr_in,
   input  wire [7:0] reg_wdata_in,
   input  wire       reg_wr_in,
   input  wire       reg_rd_in,
   output reg  [7:0] reg_rdata_out,
   // Standby indications
   input  wire       wait_mode_in,
   input  wire       stop_mode_in,
   // Reset requests
   output wire       monitor_reset_req_out,
   output wire       ext_reset_pin_out,
   output wire       ext_reset_pin_oe_out,
   output wire       standby_wake_out,
   // Event interrupt towards the system, not the processor
   output wire       event_irq_out
);

   ////////////////////////////////////////////////////////////////////////
   // Address decode
   function is_addr;
      input [3:0] a;
      input [3:0] off;
      begin
         is_addr = (a == off);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Configuration and tolerance select
   reg tolerance_select_q;
   reg monitor_power_enable_q;
   reg monitor_reset_enable_q;

   // Power/reset enables default on so monitor protects before software runs
   always @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         tolerance_select_q     <= `SVM_RST_TOL;              // [R4]
         monitor_power_enable_q <= `SVM_RST_PWR;              // [R13]
         monitor_reset_enable_q <= `SVM_RST_RST;              // [R13]
      end else if (reg_wr_in) begin
         if (is_addr(reg_addr_in, `SVM_OFF_STATUS_CONTROL)) begin
            tolerance_select_q <= reg_wdata_in[`SVM_BIT_TOL]; // [R4]
         end
         if (is_addr(reg_addr_in, `SVM_OFF_CONFIG)) begin
            monitor_power_enable_q <= reg_wdata_in[`SVM_BIT_PWR];
            monitor_reset_enable_q <= reg_wdata_in[`SVM_BIT_RST];
         end
      end
   end

   // Select line goes straight to the analog divider; new pair takes effect
   // on the next comparator sample, so a tolerance change is seen at once
   assign threshold_pair_sel_out = tolerance_select_q;         // [R5] [R9]
   // Standby does not gate the comparator power
   assign comparator_power_out = monitor_power_enable_q;      // [R11] [R12]

   ////////////////////////////////////////////////////////////////////////
   // Reset filter on the core clock
   wire low_run;
   wire low_hit;
   assign low_run = monitor_power_enable_q & below_trip_in;

   svm_filter_cnt #(
      .THRESH (6'd`SVM_RESET_FILTER_CYC)
   ) u_reset_filter (
      .clk_in   (core_clk_in),
      .rst_b_in (rst_b_in),
      .run_in   (low_run),
      .clr_in   (1'b0),
      .hit_out  (low_hit)
   );

   // Reset held until one sample above recovery point
   reg mon_reset_q;
   wire mon_reset_d;
   // A recovered sample beats a stale filter count, so one cycle above releases
   assign mon_reset_d = (low_hit & monitor_reset_enable_q & ~above_recovery_in) // [R2] [R9]
                      | (mon_reset_q & ~above_recovery_in);           // [R3]
   always @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         mon_reset_q <= 1'b0;
      end else begin
         mon_reset_q <= mon_reset_d & monitor_power_enable_q;
      end
   end

   // Resets also end wait and stop states
   assign monitor_reset_req_out = mon_reset_q;                // [R2]
   assign standby_wake_out      = mon_reset_q & (wait_mode_in | stop_mode_in); // [R11] [R12]
   // Open-drain style: drive low only while resetting
   assign ext_reset_pin_out    = 1'b0;                        // [R14]
   assign ext_reset_pin_oe_out = mon_reset_q;                 // [R14]

   ////////////////////////////////////////////////////////////////////////
   // Flag filter on the crystal clock; inputs taken as synchronous to it.
   // Trip point picked mid-window of 32..40 for margin both ways.
   reg [`SVM_CNT_W-1:0] xcnt_q;
   reg                  flag_x_q;
   always @(posedge xtal_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         xcnt_q   <= {`SVM_CNT_W{1'b0}};
         flag_x_q <= 1'b0;                                    // [R6]
      end else if (!monitor_power_enable_q || above_recovery_in) begin
         xcnt_q   <= {`SVM_CNT_W{1'b0}};
         flag_x_q <= 1'b0;                                    // [R8]
      end else if (below_trip_in) begin
         if (xcnt_q != `SVM_CNT_W'd`SVM_FLAG_CYC) begin
            xcnt_q <= xcnt_q + {{(`SVM_CNT_W-1){1'b0}}, 1'b1};
         end else begin
            flag_x_q <= 1'b1;                                 // [R7]
         end
      end else begin
         xcnt_q <= {`SVM_CNT_W{1'b0}};                         // Hold flag in band [R8]
      end
   end

   // Bring flag into core domain
   reg flag_s1_q;
   reg flag_s2_q;
   reg flag_s3_q;
   always @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         flag_s1_q <= 1'b0;
         flag_s2_q <= 1'b0;
         flag_s3_q <= 1'b0;
      end else begin
         flag_s1_q <= flag_x_q;
         flag_s2_q <= flag_s1_q;
         flag_s3_q <= flag_s2_q;
      end
   end
   wire low_supply_flag;
   assign low_supply_flag = flag_s2_q;                        // [R1]

   ////////////////////////////////////////////////////////////////////////
   // Event bits: sticky, set beats clear
   reg  [`SVM_EV_WIDTH-1:0] ev_status_q;
   reg  [`SVM_EV_WIDTH-1:0] ev_enable_q;
   reg                      mon_reset_dly_q;
   wire [`SVM_EV_WIDTH-1:0] ev_set;
   wire [`SVM_EV_WIDTH-1:0] ev_clr;
   assign ev_set[`SVM_EV_FLAG_SET]  = flag_s2_q & ~flag_s3_q;
   assign ev_set[`SVM_EV_MON_RESET] = mon_reset_q & ~mon_reset_dly_q;
   assign ev_clr = (reg_wr_in && is_addr(reg_addr_in, `SVM_OFF_EVENT_CLEAR)) ?
                   reg_wdata_in[`SVM_EV_WIDTH-1:0] : {`SVM_EV_WIDTH{1'b0}};

   genvar gi;
   generate
      for (gi = 0; gi < `SVM_EV_WIDTH; gi = gi + 1) begin : g_ev
         always @(posedge core_clk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
               ev_status_q[gi] <= 1'b0;
            end else if (ev_set[gi]) begin
               ev_status_q[gi] <= 1'b1;
            end else if (ev_clr[gi]) begin
               ev_status_q[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   always @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ev_enable_q     <= {`SVM_EV_WIDTH{1'b0}};
         mon_reset_dly_q <= 1'b0;
      end else begin
         mon_reset_dly_q <= mon_reset_q;
         if (reg_wr_in && is_addr(reg_addr_in, `SVM_OFF_EVENT_ENABLE)) begin
            ev_enable_q <= reg_wdata_in[`SVM_EV_WIDTH-1:0];
         end
      end
   end

   // System-side level only; no processor vector exists for this block
   assign event_irq_out = |(ev_status_q & ev_enable_q);      // [R10]

   ////////////////////////////////////////////////////////////////////////
   // Read data, one cycle after strobe; flag bit never written [R6]
   reg [7:0] rd_d;
   always @* begin
      rd_d = 8'h00;
      case (reg_addr_in)
         `SVM_OFF_STATUS_CONTROL: begin
            rd_d[`SVM_BIT_FLAG] = low_supply_flag;           // [R6]
            rd_d[`SVM_BIT_TOL]  = tolerance_select_q;
         end
         `SVM_OFF_CONFIG: begin
            rd_d[`SVM_BIT_PWR] = monitor_power_enable_q;
            rd_d[`SVM_BIT_RST] = monitor_reset_enable_q;
         end
         `SVM_OFF_EVENT_STATUS: rd_d[`SVM_EV_WIDTH-1:0] = ev_status_q;
         `SVM_OFF_EVENT_ENABLE: rd_d[`SVM_EV_WIDTH-1:0] = ev_enable_q;
         default:               rd_d = 8'h00;
      endcase
   end

   always @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_rd_in) begin
         reg_rdata_out <= rd_d;
      end else begin
         reg_rdata_out <= 8'h00;
      end
   end

endmodule // svm_monitor
`default_nettype wire

// [sim/svm_supply_model.sv]
`default_nettype none
// Comparator pair in front of the filter; supply given as an abstract level code
module svm_supply_model #(
   parameter int TRIP1 = 45,
   parameter int REC1  = 47,
   parameter int TRIP2 = 42,
   parameter int REC2  = 44
) (
   // Supply level and selection
   input  wire logic [7:0] supply_in,
   input  wire logic       sel_in,
   input  wire logic       power_in,
   // Comparator outputs
   output var  logic       below_out,
   output var  logic       above_out
);
   // Unpowered comparator reports neither side, so the filter sees nothing
   always_comb begin
      below_out = power_in && (int'(supply_in) <= (sel_in ? TRIP1 : TRIP2));
      above_out = power_in && (int'(supply_in) > (sel_in ? REC1 : REC2));
   end
endmodule // svm_supply_model
`default_nettype wire

// [sim/svm_monitor_properties.sv]
`default_nettype none
module svm_monitor_properties (
   // Clock, reset, comparator, standby
   input wire logic       core_clk_in, rst_b_in, below_trip_in, above_recovery_in, wait_mode_in, stop_mode_in,
   // Register port
   input wire logic [3:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in, reg_rdata_out,
   input wire logic       reg_wr_in, reg_rd_in,
   // Watched outputs
   input wire logic       threshold_pair_sel_out, comparator_power_out, monitor_reset_req_out,
   input wire logic       ext_reset_pin_out, ext_reset_pin_oe_out, standby_wake_out, event_irq_out
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_b_in);
   logic [3:0] low_cnt_q;
   logic       tol_q, pwr_q, ren_q;
   ////////////////////////////////////////////////////////////////////////
   // Shadow of tolerance and config enable bits; saturating run so long lows never wrap
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         low_cnt_q <= 4'h0;
         tol_q     <= 1'b0;
         {ren_q, pwr_q} <= 2'h3;
      end else begin
         low_cnt_q <= (below_trip_in && pwr_q) ? low_cnt_q + {3'h0, low_cnt_q != 4'hF} : 4'h0;
         if (reg_wr_in && reg_addr_in == 4'h0) tol_q <= reg_wdata_in[0];
         if (reg_wr_in && reg_addr_in == 4'h1) {ren_q, pwr_q} <= reg_wdata_in[1:0];
      end
   end
   ////////////////////////////////////////////////////////////////////////
   a_filter_early: assert property ($rose(monitor_reset_req_out) |-> $past(low_cnt_q) >= 4'h9)
      else $error("monitor reset rose before nine low samples");
   a_filter_force: assert property (low_cnt_q >= 4'hA && ren_q && $past(ren_q) |-> monitor_reset_req_out)
      else $error("monitor reset missing after long low run");
   a_reset_release: assert property (monitor_reset_req_out && above_recovery_in |=> !monitor_reset_req_out)
      else $error("monitor reset held after recovery");
   a_pin_drive: assert property (ext_reset_pin_oe_out == monitor_reset_req_out && !ext_reset_pin_out)
      else $error("reset pin not driven low with monitor reset");
   a_tol_route: assert property (threshold_pair_sel_out == tol_q)
      else $error("threshold pair select differs from tolerance bit");
   a_power_route: assert property (comparator_power_out == pwr_q)
      else $error("comparator power differs from power enable");
   a_read_status: assert property (reg_rd_in && reg_addr_in == 4'h0 |=>
      reg_rdata_out[6:0] == {6'h00, $past(threshold_pair_sel_out)})
      else $error("status read returned wrong low bits");
   a_read_config: assert property (reg_rd_in && reg_addr_in == 4'h1 |=>
      reg_rdata_out[1:0] == {$past(ren_q), $past(pwr_q)})
      else $error("config read returned wrong enables");
   a_read_unmapped: assert property (reg_rd_in && reg_addr_in > 4'h4 |=> reg_rdata_out == 8'h00)
      else $error("unmapped read not zero");
   a_standby_wake: assert property (standby_wake_out == (monitor_reset_req_out && (wait_mode_in || stop_mode_in)))
      else $error("standby wake differs from reset in standby");
   // Main scenarios reached
   c_reset: cover property ($rose(monitor_reset_req_out));
   c_wake: cover property (standby_wake_out);
   c_irq: cover property ($rose(event_irq_out));
endmodule // svm_monitor_properties
bind svm_monitor svm_monitor_properties i_props (.core_clk_in, .rst_b_in, .below_trip_in, .above_recovery_in,
   .wait_mode_in, .stop_mode_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .reg_wr_in, .reg_rd_in,
   .threshold_pair_sel_out, .comparator_power_out, .monitor_reset_req_out, .ext_reset_pin_out,
   .ext_reset_pin_oe_out, .standby_wake_out, .event_irq_out);
`default_nettype wire

// [sim/tb_top.sv]
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk_in = 1'b0, rst_b_in = 1'b0, xtal_clk_in = 1'b0;
   logic below_trip_in, above_recovery_in, threshold_pair_sel_out, comparator_power_out;
   logic [3:0] reg_addr_in = 4'h0;
   logic [7:0] reg_wdata_in = 8'h00, reg_rdata_out, supply_q = 8'h3C;
   logic reg_wr_in = 1'b0, reg_rd_in = 1'b0, wait_mode_in = 1'b0, stop_mode_in = 1'b0;
   logic monitor_reset_req_out, ext_reset_pin_out, ext_reset_pin_oe_out, standby_wake_out, event_irq_out;
   int failures = 0, num_checks = 0, cycles = 0, n;
   // Supply codes: well above, well below, between the second pair's points
   localparam logic [7:0] HIGH = 8'h3C, LOW = 8'h1E, MID = 8'h2B;
   ////////////////////////////////////////////////////////////////////////
   // Core clock 25 MHz; crystal side on an unrelated period
   always #20 core_clk_in = ~core_clk_in;
   always #53 xtal_clk_in = ~xtal_clk_in;
   svm_monitor i_svm_monitor (.core_clk_in, .rst_b_in, .xtal_clk_in, .below_trip_in, .above_recovery_in,
      .threshold_pair_sel_out, .comparator_power_out, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
      .reg_rdata_out, .wait_mode_in, .stop_mode_in, .monitor_reset_req_out, .ext_reset_pin_out,
      .ext_reset_pin_oe_out, .standby_wake_out, .event_irq_out);
   svm_supply_model i_svm_supply_model (.supply_in(supply_q), .sel_in(threshold_pair_sel_out),
      .power_in(comparator_power_out), .below_out(below_trip_in), .above_out(above_recovery_in));
   ////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Waits always land on a falling edge, clear of the sampling edge
   task automatic cyc(input int k);
      repeat (k) @(negedge core_clk_in);
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk_in) {reg_addr_in, reg_wdata_in, reg_wr_in} <= {a, d, 1'b1};
      @(posedge core_clk_in) reg_wr_in <= 1'b0;
      cyc(2);
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string nm);
      @(posedge core_clk_in) {reg_addr_in, reg_rd_in} <= {a, 1'b1};
      @(posedge core_clk_in) reg_rd_in <= 1'b0;
      @(negedge core_clk_in) chk(nm, reg_rdata_out, exp);
   endtask
   task automatic sup(input logic [7:0] v, input int k);
      @(posedge core_clk_in) supply_q <= v;
      cyc(k);
   endtask
   // Hang guard well past the few hundred cycles the tests need
   always @(posedge core_clk_in) begin
      cycles++;
      if (cycles == 4000) begin
         failures++;
         end_of_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(55));
      repeat (4) @(posedge core_clk_in);
      rst_b_in <= 1'b1;
      cyc(1);
      rd(4'h0, 8'h00, "status");
      rd(4'h1, 8'h03, "config");
      rd(4'hC, 8'h00, "unmapped");
      wr(4'h0, 8'hFF);
      rd(4'h0, 8'h01, "tolerance");
      chk("pair select", threshold_pair_sel_out, 1'b1);
      wr(4'h0, 8'h00);
      chk("pair select", threshold_pair_sel_out, 1'b0);
      $display("test registers done");
      wr(4'h1, 8'h01);
      wr(4'h4, 8'h03);
      sup(LOW, 68);
      rd(4'h0, 8'h00, "flag early");
      cyc(45);
      rd(4'h0, 8'h80, "flag late");
      chk("no reset polled", monitor_reset_req_out, 1'b0);
      chk("irq raised", event_irq_out, 1'b1);
      wr(4'h4, 8'h00);
      chk("irq masked", event_irq_out, 1'b0);
      wr(4'h4, 8'h03);
      chk("irq unmasked", event_irq_out, 1'b1);
      wr(4'h3, 8'h01);
      chk("irq cleared", event_irq_out, 1'b0);
      sup(MID, 20);
      rd(4'h0, 8'h80, "flag hold");
      sup(HIGH, 10);
      rd(4'h0, 8'h00, "flag clear");
      rd(4'h2, 8'h00, "events");
      $display("test polling done");
      wr(4'h1, 8'h03);
      for (int i = 0; i < 4; i++) begin
         n = (i == 3) ? 8 : $urandom_range(8, 1); // Last pass: longest run that must not trip
         @(posedge core_clk_in) supply_q <= LOW;
         repeat (n) @(posedge core_clk_in);
         supply_q <= HIGH;
         cyc(3);
         chk("glitch", monitor_reset_req_out, 1'b0);
      end
      sup(LOW, 14);
      chk("forced reset", monitor_reset_req_out, 1'b1);
      chk("pin enable", ext_reset_pin_oe_out, 1'b1);
      chk("pin level", ext_reset_pin_out, 1'b0);
      chk("irq reset event", event_irq_out, 1'b1);
      @(posedge core_clk_in) wait_mode_in <= 1'b1;
      cyc(1);
      chk("wake wait", standby_wake_out, 1'b1);
      @(posedge core_clk_in) {wait_mode_in, stop_mode_in} <= 2'b01;
      cyc(1);
      chk("wake stop", standby_wake_out, 1'b1);
      @(posedge core_clk_in) stop_mode_in <= 1'b0;
      sup(HIGH, 3);
      chk("release", monitor_reset_req_out, 1'b0);
      sup(MID, 20);
      chk("mid no reset", monitor_reset_req_out, 1'b0);
      wr(4'h0, 8'h01);
      cyc(14);
      chk("tolerance reset", monitor_reset_req_out, 1'b1);
      sup(HIGH, 3);
      chk("release", monitor_reset_req_out, 1'b0);
      $display("test forced reset done");
      // Reset in mid-run with the flag set and a monitor reset standing
      sup(LOW, 110);
      rd(4'h0, 8'h81, "flag before reset");
      @(posedge core_clk_in) rst_b_in <= 1'b0;
      repeat (2) @(posedge core_clk_in);
      rst_b_in <= 1'b1;
      cyc(1);
      chk("reset cleared", monitor_reset_req_out, 1'b0);
      rd(4'h0, 8'h00, "flag after reset");
      rd(4'h1, 8'h03, "config after reset");
      cyc(12);
      chk("reset unconfigured", monitor_reset_req_out, 1'b1);
      sup(HIGH, 3);
      chk("release after reset", monitor_reset_req_out, 1'b0);
      $display("test mid-run reset done");
      end_of_test();
   end
endmodule // tb_top
`default_nettype wire
